/* File: rtl/cell_statistics_event_recorder.sv */
/*
  Cell statistics and event recorder: turns per-cell event reports into
  counter and sticky-word updates in external memory, drives forced
  underrun pulses, and keeps the management cell interrupt.
  Assumes a memory arbiter in front of the external SRAM and a processor
  on the plain register port that polls and clears the memory words.
*/
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
module cell_statistics_event_recorder
  import stat_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // Cell event reports
  input wire logic ev_valid,
  input wire logic [QUEUE_W-1:0] ev_queue,
  input wire logic [NUM_CAUSES-1:0] ev_cause,
  output logic ev_ready,
  // Forced underrun to the receive processor
  output logic force_underrun,
  output logic [QUEUE_W-1:0] force_queue,
  // Interrupt
  output logic mgmt_cell_irq,
  // Memory arbiter
  output logic mem_req,
  output logic mem_we,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [DATA_W-1:0] mem_wdata,
  input wire logic mem_gnt,
  input wire logic mem_rvalid,
  input wire logic [DATA_W-1:0] mem_rdata
);

  typedef enum logic [1:0] {
    S_IDLE = 2'b01,
    S_WAIT = 2'b10
  } rec_state_type;

  rec_state_type state_r;
  logic [NUM_JOBS-1:0] pend_r;
  logic [JOB_W-1:0] job_r;
  logic [QUEUE_W-1:0] queue_r;
  logic [DATA_W-1:0] sticky_r;
  logic start_r;
  logic eng_done;
  logic ev_ready_r;
  logic mask_r;
  logic latch_r;
  logic irq_r;
  logic force_r;
  logic [QUEUE_W-1:0] force_q_r;
  logic [DATA_W-1:0] rdata_r;
  logic take;
  logic clr_cmd;
  logic mgmt_arrive;
  logic [NUM_JOBS-1:0] jobs_nxt;
  logic [ADDR_W-1:0] job_addr_w;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // ==========================================================
  // Decode functions

  // Counter increments that one event report asks for.
  function automatic logic [NUM_CNT-1:0] cnt_bits(input logic [NUM_CAUSES-1:0] c);
    logic [NUM_CNT-1:0] m;
    m = '0;
    m[J_MGMT] = c[C_MGMT_CELL];
    m[J_MGMT_DROP] = c[C_MGMT_DROP];
    m[J_SEQ_PROT] = c[C_SNP_ERR];
    m[J_SEQ_ERR] = c[C_SEQ_WAS_SYNC] & c[C_SEQ_NOW_LOST];
    m[J_RX_BILL] = c[C_RX_BILL];
    m[J_RX_DROP] = c[C_RX_DROP];
    m[J_UNDERRUN] = c[C_UNDERRUN];
    m[J_LOST] = c[C_LOST];
    m[J_OVERRUN] = c[C_OVERRUN];
    m[J_REFRAME] = c[C_REFRAME];
    m[J_PTR_PAR] = c[C_PTR_PAR];
    m[J_MISINS] = c[C_MISINS];
    m[J_TX_BILL] = c[C_TX_BILL];
    m[J_TX_COND] = c[C_TX_COND];
    // A cell held back counts only when one of the three causes is present.
    m[J_TX_SUPP] = c[C_TX_NOT_SENT] & (c[C_LINE_RESYNC] | c[C_SUPPRESS] |
                   (c[C_TX_ACTIVE] & c[C_HS_MODE]));
    cnt_bits = m;
  endfunction

  // Events that force an underrun on the reporting queue.
  function automatic logic forces(input logic [NUM_CAUSES-1:0] c);
    forces = c[C_OVERRUN] | c[C_FAST_SN_DROP] | c[C_PTR_MISMATCH];
  endfunction

  // Lowest pending job, so work always runs in a fixed order.
  function automatic logic [JOB_W-1:0] first_job(input logic [NUM_JOBS-1:0] p);
    logic [JOB_W-1:0] j;
    j = '0;
    for (int i = NUM_JOBS - 1; i >= 0; i--) begin
      if (p[i]) begin
        j = JOB_W'(i);
      end
    end
    first_job = j;
  endfunction

  // Memory word of a job: globals, per-queue counter blocks, sticky words.
  function automatic logic [ADDR_W-1:0] job_addr(input logic [JOB_W-1:0] j,
                                                 input logic [QUEUE_W-1:0] q);
    logic [ADDR_W-1:0] a;
    a = GLOBAL_BASE + ADDR_W'(j);
    if (j == JOB_W'(STICKY_JOB)) begin
      a = STICKY_BASE + ADDR_W'(q);
    end else if (j >= JOB_W'(FIRST_QUEUE_JOB)) begin
      a = CNT_BASE + ADDR_W'({j - JOB_W'(FIRST_QUEUE_JOB), 8'h00}) + ADDR_W'(q);
    end
    job_addr = a;
  endfunction

  // ==========================================================
  // Event acceptance

  // One report is taken at a time; the source stalls while jobs drain.
  assign take = ev_valid & ev_ready_r;
  assign jobs_nxt = {|sticky_bits(ev_cause), cnt_bits(ev_cause)};
  assign job_addr_w = job_addr(job_r, queue_r);

  // Queue number and sticky pattern are held until the last job ends.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      queue_r <= 8'h00;
      sticky_r <= 16'h0000;
    end else if (take) begin
      queue_r <= ev_queue;
      sticky_r <= sticky_bits(ev_cause);
    end
  end

  // Ready returns only once the pending set is empty and the engine idle.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ev_ready_r <= 1'b0;
    end else if (take) begin
      ev_ready_r <= 1'b0;
    end else begin
      ev_ready_r <= (state_r == S_IDLE) && (pend_r == '0) && !start_r;
    end
  end

  // Forced underrun pulse, one cycle after the offending report.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      force_r <= 1'b0;
      force_q_r <= 8'h00;
    end else begin
      force_r <= take && forces(ev_cause);
      if (take) begin
        force_q_r <= ev_queue;
      end
    end
  end

  // ==========================================================
  // Job sequencing

  // Pending set and job issue; a load only happens with the set empty.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_r <= S_IDLE;
      pend_r <= '0;
      job_r <= '0;
      start_r <= 1'b0;
    end else begin
      start_r <= 1'b0;
      if (take) begin
        pend_r <= jobs_nxt;
      end
      unique case (state_r)
        S_IDLE: begin
          if (pend_r != '0) begin
            job_r <= first_job(pend_r);
            pend_r[first_job(pend_r)] <= 1'b0;
            start_r <= 1'b1;
            state_r <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (eng_done) begin
            state_r <= S_IDLE;
          end
        end
      endcase
    end
  end

  // Counters increment; the sticky word job ORs in the new event bits.
  stat_rmw_engine u_engine (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .start(start_r),
    .op_or(job_r == JOB_W'(STICKY_JOB)),
    .addr(job_addr_w),
    .or_mask(sticky_r),
    .done(eng_done),
    .mem_req(mem_req),
    .mem_we(mem_we),
    .mem_addr(mem_addr),
    .mem_wdata(mem_wdata),
    .mem_gnt(mem_gnt),
    .mem_rvalid(mem_rvalid),
    .mem_rdata(mem_rdata)
  );

  // ==========================================================
  // Register port and interrupt

  assign clr_cmd = reg_wr && (reg_addr == REG_CMD) && reg_wdata[CMD_CLR_BIT];
  assign mgmt_arrive = take && ev_cause[C_MGMT_CELL];

  // Mask bit, set after reset so nothing fires before software is ready.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      mask_r <= CTRL_MASK_RESET;
    end else if (reg_wr && reg_addr == REG_CTRL) begin
      mask_r <= reg_wdata[CTRL_MASK_BIT];
    end
  end

  // Latch: an unmasked arrival in the same cycle as a clear still sets it.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      latch_r <= 1'b0;
    end else if (mgmt_arrive && !mask_r) begin
      latch_r <= 1'b1;
    end else if (clr_cmd || mask_r) begin
      latch_r <= 1'b0;
    end
  end

  // Interrupt output, gated by the mask so a set mask drops it on the next clock.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= latch_r && !mask_r;
    end
  end

  // Read data stand for one cycle only; unmapped and command read zero.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= 16'h0000;
      if (reg_rd && reg_addr == REG_CTRL) begin
        rdata_r[CTRL_MASK_BIT] <= mask_r;
      end
      if (reg_rd && reg_addr == REG_STAT) begin
        rdata_r[STAT_LATCH_BIT] <= latch_r;
        rdata_r[STAT_BUSY_BIT] <= !ev_ready_r;
      end
    end
  end

  assign reg_rdata = rdata_r;
  assign ev_ready = ev_ready_r;
  assign force_underrun = force_r;
  assign force_queue = force_q_r;
  assign mgmt_cell_irq = irq_r;

  // ==========================================================
  // Checks

  sequence s_take;
    take;
  endsequence

  property p_seq_count;
    s_take |=> pend_r[J_SEQ_ERR] ==
      ($past(ev_cause[C_SEQ_WAS_SYNC]) && $past(ev_cause[C_SEQ_NOW_LOST]));
  endproperty
  a_seq_count: assert property (p_seq_count) else $error("sequence error miscounted");

  property p_mgmt_count;
    s_take |=> pend_r[J_MGMT] == $past(ev_cause[C_MGMT_CELL]) &&
      pend_r[J_MGMT_DROP] == $past(ev_cause[C_MGMT_DROP]);
  endproperty
  a_mgmt_count: assert property (p_mgmt_count) else $error("management count wrong");

  property p_supp_count;
    s_take and !ev_cause[C_TX_NOT_SENT] |=> !pend_r[J_TX_SUPP];
  endproperty
  a_supp_count: assert property (p_supp_count) else $error("suppressed count spurious");

  property p_rx_counts;
    s_take |=> pend_r[J_SEQ_PROT] == $past(ev_cause[C_SNP_ERR]) &&
      pend_r[J_RX_BILL] == $past(ev_cause[C_RX_BILL]) &&
      pend_r[J_OVERRUN] == $past(ev_cause[C_OVERRUN]) &&
      pend_r[J_MISINS] == $past(ev_cause[C_MISINS]) &&
      pend_r[J_TX_COND] == $past(ev_cause[C_TX_COND]);
  endproperty
  a_rx_counts: assert property (p_rx_counts) else $error("counter job mismatch");

  property p_sticky_word;
    s_take |=> sticky_r[0] == $past(ev_cause[C_IN_UNDERRUN]) &&
      sticky_r[12] == $past(ev_cause[C_PTR_MISMATCH]) && pend_r[STICKY_JOB] == (sticky_r != '0);
  endproperty
  a_sticky_word: assert property (p_sticky_word) else $error("sticky word job wrong");

  property p_force;
    s_take and forces(ev_cause) |=> force_underrun && force_queue == $past(ev_queue);
  endproperty
  a_force: assert property (p_force) else $error("forced underrun missing");

  property p_irq_set;
    (mgmt_arrive && !mask_r) ##1 !mask_r |=> mgmt_cell_irq;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("interrupt not raised");

  property p_irq_clear;
    clr_cmd && !mgmt_arrive |=> ##1 !mgmt_cell_irq;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("interrupt not cleared");

  property p_irq_masked;
    mask_r |=> !mgmt_cell_irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("masked interrupt seen");

  property p_busy;
    s_take |=> !ev_ready ##1 (ev_ready == ($past(jobs_nxt, 2) == '0));
  endproperty
  a_busy: assert property (p_busy) else $error("ready during jobs");

endmodule

/* File: rtl/stat_pkg.sv */
/*
  Shared constants, event cause positions and the sticky word decode function for the
  cell statistics and event recorder.
  Assumes a 128K x 16 external memory reached through a memory arbiter.
*/
package stat_pkg;

  // ==========================================================
  // Widths and job numbering
  localparam int ADDR_W = 17;
  localparam int DATA_W = 16;
  localparam int QUEUE_W = 8;
  localparam int JOB_W = 4;
  localparam int NUM_JOBS = 16;
  localparam int NUM_CNT = 15;
  localparam int STICKY_JOB = 15;
  localparam int FIRST_QUEUE_JOB = 2;

  // ==========================================================
  // Memory map of counters and sticky words
  localparam logic [ADDR_W-1:0] CNT_BASE = 17'h1_0000;
  localparam logic [ADDR_W-1:0] STICKY_BASE = 17'h1_F000;
  localparam logic [ADDR_W-1:0] GLOBAL_BASE = 17'h1_FF00;

  // ==========================================================
  // Counter job positions
  localparam int J_MGMT = 0;
  localparam int J_MGMT_DROP = 1;
  localparam int J_SEQ_PROT = 2;
  localparam int J_SEQ_ERR = 3;
  localparam int J_RX_BILL = 4;
  localparam int J_RX_DROP = 5;
  localparam int J_UNDERRUN = 6;
  localparam int J_LOST = 7;
  localparam int J_OVERRUN = 8;
  localparam int J_REFRAME = 9;
  localparam int J_PTR_PAR = 10;
  localparam int J_MISINS = 11;
  localparam int J_TX_BILL = 12;
  localparam int J_TX_COND = 13;
  localparam int J_TX_SUPP = 14;

  // ==========================================================
  // Event cause bit positions
  localparam int C_MGMT_CELL = 0;
  localparam int C_MGMT_DROP = 1;
  localparam int C_SNP_ERR = 2;
  localparam int C_SEQ_WAS_SYNC = 3;
  localparam int C_SEQ_NOW_LOST = 4;
  localparam int C_RX_BILL = 5;
  localparam int C_RX_DROP = 6;
  localparam int C_UNDERRUN = 7;
  localparam int C_LOST = 8;
  localparam int C_OVERRUN = 9;
  localparam int C_REFRAME = 10;
  localparam int C_PTR_PAR = 11;
  localparam int C_MISINS = 12;
  localparam int C_TX_BILL = 13;
  localparam int C_TX_COND = 14;
  localparam int C_TX_NOT_SENT = 15;
  localparam int C_LINE_RESYNC = 16;
  localparam int C_TX_ACTIVE = 17;
  localparam int C_HS_MODE = 18;
  localparam int C_SUPPRESS = 19;
  localparam int C_IN_UNDERRUN = 20;
  localparam int C_RESUME = 21;
  localparam int C_FAST_SN_DROP = 22;
  localparam int C_FORCED_DROP = 23;
  localparam int C_BLANK_DROP = 24;
  localparam int C_RX_CELL = 25;
  localparam int C_NOPTR_DROP = 26;
  localparam int C_PTR_VALID = 27;
  localparam int C_SRTS_RESUME = 28;
  localparam int C_SRTS_UNDER = 29;
  localparam int C_PTR_MISMATCH = 30;
  localparam int NUM_CAUSES = 31;

  // ==========================================================
  // Register port map and fields
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;
  localparam int CMD_CLR_BIT = 0;
  localparam int CTRL_MASK_BIT = 0;
  localparam int STAT_LATCH_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam logic CTRL_MASK_RESET = 1'b1;

  // Sticky word of a queue: thirteen receive event bits, upper bits zero.
  function automatic logic [DATA_W-1:0] sticky_bits(input logic [NUM_CAUSES-1:0] c);
    sticky_bits = {3'h0, c[C_PTR_MISMATCH], c[C_SRTS_UNDER], c[C_SRTS_RESUME],
                   c[C_PTR_PAR], c[C_PTR_VALID], c[C_NOPTR_DROP], c[C_RX_CELL],
                   c[C_BLANK_DROP], c[C_FORCED_DROP], c[C_FAST_SN_DROP],
                   c[C_RESUME], c[C_OVERRUN], c[C_IN_UNDERRUN]};
  endfunction

endpackage

/* File: rtl/stat_rmw_engine.sv */
/*
  Read-modify-write engine: one word of external memory per start pulse,
  either incremented with wrap or ORed with a mask.
  Assumes the arbiter grants a held request with a one-cycle mem_gnt and
  returns read data later with a one-cycle mem_rvalid.
*/
`timescale 1ns/100ps
module stat_rmw_engine
  import stat_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Job request
  input wire logic start,
  input wire logic op_or,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] or_mask,
  output logic done,
  // Memory arbiter
  output logic mem_req,
  output logic mem_we,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [DATA_W-1:0] mem_wdata,
  input wire logic mem_gnt,
  input wire logic mem_rvalid,
  input wire logic [DATA_W-1:0] mem_rdata
);

  typedef enum logic [3:0] {
    E_IDLE = 4'b0001,
    E_RD = 4'b0010,
    E_WAIT = 4'b0100,
    E_WR = 4'b1000
  } eng_state_type;

  eng_state_type state_r;
  logic op_r;
  logic [DATA_W-1:0] mask_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // ==========================================================
  // Handshake sequencing: read request, read data, write request.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_r <= E_IDLE;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state_r)
        E_IDLE: begin
          if (start) begin
            mem_req <= 1'b1;
            state_r <= E_RD;
          end
        end
        E_RD: begin
          if (mem_gnt) begin
            mem_req <= 1'b0;
            state_r <= E_WAIT;
          end
        end
        E_WAIT: begin
          if (mem_rvalid) begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            state_r <= E_WR;
          end
        end
        E_WR: begin
          if (mem_gnt) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            done <= 1'b1;
            state_r <= E_IDLE;
          end
        end
      endcase
    end
  end

  // Job data; the address stays put for the whole read-modify-write.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      op_r <= 1'b0;
      mask_r <= 16'h0000;
      mem_addr <= 17'h0_0000;
      mem_wdata <= 16'h0000;
    end else begin
      if (state_r == E_IDLE && start) begin
        op_r <= op_or;
        mask_r <= or_mask;
        mem_addr <= addr;
      end
      if (state_r == E_WAIT && mem_rvalid) begin
        // The counter is never cleared here; all ones wraps to zero.
        mem_wdata <= op_r ? (mem_rdata | mask_r) : (mem_rdata + 16'h0001);
      end
    end
  end

  sequence s_rd_back;
    state_r == E_WAIT && mem_rvalid;
  endsequence

  property p_cnt_wrap;
    s_rd_back and !op_r |=> mem_wdata == $past(mem_rdata) + 16'h0001;
  endproperty
  a_cnt_wrap: assert property (p_cnt_wrap) else $error("counter not incremented");

  property p_rmw_same;
    s_rd_back |=> mem_req && mem_we && mem_addr == $past(mem_addr);
  endproperty
  a_rmw_same: assert property (p_rmw_same) else $error("write not to read address");

  property p_sticky_keep;
    s_rd_back and op_r |=> (mem_wdata & $past(mem_rdata)) == $past(mem_rdata);
  endproperty
  a_sticky_keep: assert property (p_sticky_keep) else $error("sticky bit lost");

endmodule

/* File: sim/cell_statistics_event_recorder_tb.sv */
/*
  Self-checking bench for the cell statistics and event recorder.
  Assumes stat_mem_model as the far side and backdoor access to its array.
*/
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %s expected %h seen %h", nm, e, g); end end
module cell_statistics_event_recorder_tb
  import stat_pkg::*;
;
  // ==========================================================
  // Signals
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ev_valid = 1'b0;
  logic [QUEUE_W-1:0] ev_queue = '0;
  logic [NUM_CAUSES-1:0] ev_cause = '0;
  logic slow = 1'b0;
  logic [DATA_W-1:0] reg_rdata, mem_wdata, mem_rdata;
  logic [ADDR_W-1:0] mem_addr;
  logic [QUEUE_W-1:0] force_queue;
  logic ev_ready, force_underrun, mgmt_cell_irq, mem_req, mem_we, mem_gnt, mem_rvalid;
  int n_errors = 0;
  int n_checks = 0;
  int n_run = 0;

  cell_statistics_event_recorder dut_u (.clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .ev_valid, .ev_queue, .ev_cause, .ev_ready, .force_underrun,
    .force_queue, .mgmt_cell_irq, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_gnt,
    .mem_rvalid, .mem_rdata);
  stat_mem_model mem_u (.clk_sys, .slow, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_gnt,
    .mem_rvalid, .mem_rdata);

  // 200 MHz system clock.
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  // One cause bit as a report vector.
  function automatic logic [NUM_CAUSES-1:0] b(input int p);
    return NUM_CAUSES'(1) << p;
  endfunction

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Register write: one strobe cycle.
  task automatic reg_write(input logic [3:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // Register read; the data stand only in the cycle after the strobe.
  task automatic reg_chk(input logic [3:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 `CHK("register", e, reg_rdata);
  endtask

  // One report on a fresh queue, then its counter, sticky word and forced
  // underrun are checked. The sticky word is preset with a bit the device
  // never sets, so an overwrite instead of an OR shows up.
  task automatic run(input logic [NUM_CAUSES-1:0] c, input int job, input int inc,
                     input logic [DATA_W-1:0] stk, input logic frc);
    logic [QUEUE_W-1:0] q;
    logic [ADDR_W-1:0] a;
    logic [ADDR_W-1:0] sa;
    logic [DATA_W-1:0] pre;
    logic f;
    int i;
    q = QUEUE_W'(n_run * 11 + 3);
    sa = STICKY_BASE + ADDR_W'(q);
    a = CNT_BASE + ADDR_W'((job - 2) * 256) + ADDR_W'(q);
    if (job < 2) a = GLOBAL_BASE + ADDR_W'(job);
    pre = (n_run == 0) ? 16'hFFFF : DATA_W'(n_run * 291);
    mem_u.mem[a] = pre;
    mem_u.mem[sa] = 16'h8000;
    slow <= n_run[0];
    @(posedge clk_sys);
    ev_valid <= 1'b1;
    ev_queue <= q;
    ev_cause <= c;
    i = 0;
    do begin
      @(negedge clk_sys);
      i++;
    end while (ev_ready !== 1'b1 && i < 500);
    if (ev_ready !== 1'b1) n_errors++;
    @(posedge clk_sys);
    ev_valid <= 1'b0;
    #1 f = force_underrun;
    i = 0;
    do begin
      @(negedge clk_sys);
      i++;
    end while (ev_ready !== 1'b1 && i < 500);
    if (ev_ready !== 1'b1) n_errors++;
    if (job >= 0) `CHK("counter", pre + DATA_W'(inc), mem_u.mem[a]);
    `CHK("sticky", 16'h8000 | stk, mem_u.mem[sa]);
    `CHK("force", frc, f);
    if (frc) `CHK("force queue", q, force_queue);
    n_run++;
  endtask

  // Hang guard, far beyond the several hundred cycles the run needs.
  initial begin
    #100000;
    n_errors++;
    finish_test();
  end

  // Reset, register defaults, every cause, then the interrupt path.
  initial begin
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    reg_chk(REG_CTRL, 16'h0001);
    reg_chk(REG_CMD, 16'h0000);
    reg_chk(REG_STAT, 16'h0000);
    reg_chk(4'hC, 16'h0000);
    run(b(C_SNP_ERR), J_SEQ_PROT, 1, 16'h0000, 0);
    run(b(C_SEQ_WAS_SYNC) | b(C_SEQ_NOW_LOST), J_SEQ_ERR, 1, 16'h0000, 0);
    run(b(C_SEQ_NOW_LOST), J_SEQ_ERR, 0, 16'h0000, 0);
    run(b(C_RX_BILL), J_RX_BILL, 1, 16'h0000, 0);
    run(b(C_RX_DROP), J_RX_DROP, 1, 16'h0000, 0);
    run(b(C_UNDERRUN), J_UNDERRUN, 1, 16'h0000, 0);
    run(b(C_LOST), J_LOST, 1, 16'h0000, 0);
    run(b(C_OVERRUN), J_OVERRUN, 1, 16'h0002, 1);
    run(b(C_REFRAME), J_REFRAME, 1, 16'h0000, 0);
    run(b(C_PTR_PAR), J_PTR_PAR, 1, 16'h0200, 0);
    run(b(C_MISINS), J_MISINS, 1, 16'h0000, 0);
    run(b(C_TX_BILL), J_TX_BILL, 1, 16'h0000, 0);
    run(b(C_TX_COND), J_TX_COND, 1, 16'h0000, 0);
    run(b(C_TX_NOT_SENT) | b(C_LINE_RESYNC), J_TX_SUPP, 1, 16'h0000, 0);
    run(b(C_TX_NOT_SENT) | b(C_SUPPRESS), J_TX_SUPP, 1, 16'h0000, 0);
    run(b(C_TX_NOT_SENT) | b(C_TX_ACTIVE) | b(C_HS_MODE), J_TX_SUPP, 1, 16'h0000, 0);
    run(b(C_TX_NOT_SENT) | b(C_TX_ACTIVE), J_TX_SUPP, 0, 16'h0000, 0);
    run(b(C_FAST_SN_DROP), -1, 0, 16'h0008, 1);
    run(b(C_PTR_MISMATCH), -1, 0, 16'h1000, 1);
    run(b(C_IN_UNDERRUN) | b(C_RESUME), -1, 0, 16'h0005, 0);
    run(b(C_FORCED_DROP) | b(C_BLANK_DROP), -1, 0, 16'h0030, 0);
    run(b(C_RX_CELL) | b(C_NOPTR_DROP), -1, 0, 16'h00C0, 0);
    run(b(C_PTR_VALID) | b(C_SRTS_RESUME) | b(C_SRTS_UNDER), -1, 0, 16'h0D00, 0);
    run(b(C_MGMT_DROP), J_MGMT_DROP, 1, 16'h0000, 0);
    run(b(C_MGMT_CELL), J_MGMT, 1, 16'h0000, 0);
    `CHK("irq", 1'b0, mgmt_cell_irq);
    reg_write(REG_CTRL, 16'h0000);
    run(b(C_MGMT_CELL), J_MGMT, 1, 16'h0000, 0);
    `CHK("irq", 1'b1, mgmt_cell_irq);
    reg_chk(REG_STAT, 16'h0001);
    reg_write(REG_CMD, 16'h0001);
    repeat (3) @(posedge clk_sys);
    #1 `CHK("irq", 1'b0, mgmt_cell_irq);
    run(b(C_MGMT_CELL), J_MGMT, 1, 16'h0000, 0);
    `CHK("irq", 1'b1, mgmt_cell_irq);
    reg_write(REG_CTRL, 16'h0001);
    repeat (3) @(posedge clk_sys);
    #1 `CHK("irq", 1'b0, mgmt_cell_irq);
    finish_test();
  end
endmodule

/* File: sim/stat_mem_model.sv */
/*
  Memory arbiter and word memory standing in for the external SRAM.
  Assumes a single requester; the bench presets and inspects mem directly.
*/
`timescale 1ns/100ps
module stat_mem_model
  import stat_pkg::*;
(
  // Clock and pacing
  input wire logic clk_sys,
  input wire logic slow,
  // Requests
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [DATA_W-1:0] mem_wdata,
  // Answers
  output logic mem_gnt,
  output logic mem_rvalid,
  output logic [DATA_W-1:0] mem_rdata
);
  // ==========================================================
  // Storage and pending read
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [ADDR_W-1:0] rd_addr_r;
  logic rd_pend_r;
  int wait_r;
  int lat_r;

  // Everything starts idle with the memory cleared.
  initial begin
    foreach (mem[i]) mem[i] = '0;
    {mem_gnt, mem_rvalid, rd_pend_r, rd_addr_r, mem_rdata, wait_r, lat_r} = '0;
  end

  // Grants come late when slow is set. Idle data lines toggle every cycle,
  // so a stale word can never pass for a fresh answer.
  always @(posedge clk_sys) begin
    mem_gnt <= 1'b0;
    mem_rvalid <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_gnt) begin
      if (wait_r > 0) begin
        wait_r <= wait_r - 1;
      end else begin
        mem_gnt <= 1'b1;
        wait_r <= slow ? 3 : 0;
        if (mem_we) begin
          mem[mem_addr] <= mem_wdata;
        end else begin
          rd_pend_r <= 1'b1;
          rd_addr_r <= mem_addr;
          lat_r <= slow ? 5 : 1;
        end
      end
    end
    if (rd_pend_r && lat_r > 1) begin
      lat_r <= lat_r - 1;
    end else if (rd_pend_r) begin
      mem_rvalid <= 1'b1;
      mem_rdata <= mem[rd_addr_r];
      rd_pend_r <= 1'b0;
    end
  end
endmodule
